/* File: vmr_pkg.sv */
// Constants, types and decode helpers for the monitor fault reaction block
package vmr_pkg;
  localparam int NUM_MON = 4;
  localparam int NUM_REG = 8;
  localparam int CNT_W = 13;
  localparam int FLT_W = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OV_T0_NS = 25000;
  localparam int OV_T1_NS = 45000;
  localparam int UV_T0_NS = 5000;
  localparam int UV_T1_NS = 15000;
  localparam int UV_T2_NS = 25000;
  localparam int UV_T3_NS = 40000;
  localparam int OV_T0_CYC = OV_T0_NS / CLK_PERIOD_NS;
  localparam int OV_T1_CYC = OV_T1_NS / CLK_PERIOD_NS;
  localparam int UV_T0_CYC = UV_T0_NS / CLK_PERIOD_NS;
  localparam int UV_T1_CYC = UV_T1_NS / CLK_PERIOD_NS;
  localparam int UV_T2_CYC = UV_T2_NS / CLK_PERIOD_NS;
  localparam int UV_T3_CYC = UV_T3_NS / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = 16;
  localparam logic [1:0] REACT_NONE = 2'h0;
  localparam logic [1:0] REACT_FS = 2'h1;
  localparam logic [1:0] OV_REACT_RST = 2'h2;
  localparam logic [1:0] UV_REACT_RST = 2'h1;
  localparam logic [1:0] LIMIT_RST = 2'h1;
  localparam logic [1:0] MID_REACT_RST = 2'h2;
  localparam logic [3:0] REG_EXTERNAL = 4'h8;
  localparam logic [FLT_W-1:0] CNT_START = 4'h1;
  localparam logic [FLT_W-1:0] FLT_ONE = 4'h1;

  typedef enum logic [1:0] {
    SEV_NONE,
    SEV_FS,
    SEV_RST
  } vmr_sev_t;

  typedef enum {
    ST_NORMAL,
    ST_FS,
    ST_RST,
    ST_DEEP
  } vmr_state_t;

  function automatic vmr_sev_t vmr_sev(input logic [1:0] code);
    if (code == REACT_NONE) begin
      vmr_sev = SEV_NONE;
    end else if (code == REACT_FS) begin
      vmr_sev = SEV_FS;
    end else begin
      vmr_sev = SEV_RST;
    end
  endfunction

  function automatic logic [FLT_W-1:0] vmr_final(input logic [1:0] code);
    case (code)
      2'h0: vmr_final = 4'h2;
      2'h1: vmr_final = 4'h6;
      2'h2: vmr_final = 4'h8;
      default: vmr_final = 4'hc;
    endcase
  endfunction

  function automatic logic [FLT_W-1:0] vmr_mid(input logic [1:0] code);
    case (code)
      2'h0: vmr_mid = 4'h1;
      2'h1: vmr_mid = 4'h3;
      2'h2: vmr_mid = 4'h4;
      default: vmr_mid = 4'h6;
    endcase
  endfunction
endpackage

/* File: vmr_mon_if.sv */
// Carrier between the top and one monitor's deglitch filter
`timescale 1ns/100ps
interface vmr_mon_if;
  logic ov_raw;
  logic uv_raw;
  logic [vmr_pkg::CNT_W-1:0] ov_len;
  logic [vmr_pkg::CNT_W-1:0] uv_len;
  logic ov_filt;
  logic uv_filt;
  modport top (output ov_raw, output uv_raw, output ov_len,
               output uv_len, input ov_filt, input uv_filt);
  modport filt (input ov_raw, input uv_raw, input ov_len,
                input uv_len, output ov_filt, output uv_filt);
endinterface

/* File: vmr_deglitch.sv */
// Deglitch filter for one monitor's overvoltage and undervoltage levels
`timescale 1ns/100ps
module vmr_deglitch (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  vmr_mon_if.filt mon
);
  logic ov_filt;
  logic uv_filt;
  logic [vmr_pkg::CNT_W-1:0] ov_cnt;
  logic [vmr_pkg::CNT_W-1:0] uv_cnt;
  logic next_ov_filt;
  logic next_uv_filt;
  logic [vmr_pkg::CNT_W-1:0] next_ov_cnt;
  logic [vmr_pkg::CNT_W-1:0] next_uv_cnt;

  // Output changes only after the input differs for the full length
  always_comb begin
    next_ov_filt = ov_filt;
    next_uv_filt = uv_filt;
    next_ov_cnt = '0;
    next_uv_cnt = '0;
    if (mon.ov_raw != ov_filt) begin
      if (ov_cnt + 1'b1 >= mon.ov_len) begin // R5
        next_ov_filt = mon.ov_raw;
      end else begin
        next_ov_cnt = ov_cnt + 1'b1;
      end
    end
    if (mon.uv_raw != uv_filt) begin
      if (uv_cnt + 1'b1 >= mon.uv_len) begin // R5
        next_uv_filt = mon.uv_raw;
      end else begin
        next_uv_cnt = uv_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ov_filt <= 1'b0;
      uv_filt <= 1'b0;
      ov_cnt <= '0;
      uv_cnt <= '0;
    end else begin
      ov_filt <= next_ov_filt;
      uv_filt <= next_uv_filt;
      ov_cnt <= next_ov_cnt;
      uv_cnt <= next_uv_cnt;
    end
  end

  assign mon.ov_filt = ov_filt;
  assign mon.uv_filt = uv_filt;
endmodule

/* File: vmr_top.sv */
// Monitor fault reaction and fault error counter, top level
//
// Summary of operation
// R1: Host selects regulator; overvoltage switches it off.
// R2: External regulator: only set overvoltage flag.
// R3: OV code: none, fail-safe, fail-safe plus reset.
// R4: UV code decodes alike, defaults fail-safe only.
// R5: Deglitch comparators; selectable OV and UV times.
// R6: Counter starts at one after reset, standby.
// R7: Counter at final value enters deep fail-safe.
// R8: Limit code writable only in initial phase.
// R9: Limit code maps to final and intermediate.
// R10: Intermediate value applies its own reaction code.
// R11: Present intermediate-reached and final-reached outputs.
// R12: Released outputs: reacting faults add one.
// R13: Fail-safe asserted: watchdog maximum adds one.
// R14: Counter saturates; intermediate fires on reaching.
// R15: Config defaults restored only by power-on reset.
`timescale 1ns/100ps
module vmr_top #(
  parameter int OV_LONG_CYC = vmr_pkg::OV_T1_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic standby_exit_i,
  input wire logic [vmr_pkg::NUM_MON-1:0] mon_ov_raw_i,
  input wire logic [vmr_pkg::NUM_MON-1:0] mon_uv_raw_i,
  input wire logic [vmr_pkg::NUM_MON-1:0] monitor_ov_filter_select_i,
  input wire logic [2*vmr_pkg::NUM_MON-1:0] monitor_uv_filter_select_i,
  input wire logic initial_failsafe_phase_i,
  input wire logic cfg_write_i,
  input wire logic [4*vmr_pkg::NUM_MON-1:0] monitor_regulator_select_i,
  input wire logic [2*vmr_pkg::NUM_MON-1:0] monitor_overvoltage_reaction_i,
  input wire logic [2*vmr_pkg::NUM_MON-1:0] monitor_undervoltage_reaction_i,
  input wire logic [1:0] fault_counter_limit_code_i,
  input wire logic [1:0] fault_counter_midpoint_reaction_i,
  input wire logic wd_err_max_i,
  input wire logic failsafe_release_i,
  input wire logic [vmr_pkg::NUM_MON-1:0] ov_flag_clear_i,
  input wire logic [vmr_pkg::NUM_MON-1:0] uv_flag_clear_i,
  output logic [vmr_pkg::NUM_REG-1:0] regulator_off_o,
  output logic [vmr_pkg::NUM_MON-1:0] ov_flag_o,
  output logic [vmr_pkg::NUM_MON-1:0] uv_flag_o,
  output logic reset_output_pin_n_o,
  output logic failsafe_output_pin_n_o,
  output logic deep_failsafe_o,
  output logic [vmr_pkg::FLT_W-1:0] fault_counter_value_o,
  output logic cnt_intermediate_o,
  output logic cnt_final_o
);
  localparam int NM = vmr_pkg::NUM_MON;

  vmr_mon_if mon_bus [NM] ();
  logic [NM-1:0] ov_filt;
  logic [NM-1:0] uv_filt;

  genvar gi;
  generate
    for (gi = 0; gi < NM; gi++) begin : g_mon
      assign mon_bus[gi].ov_raw = mon_ov_raw_i[gi];
      assign mon_bus[gi].uv_raw = mon_uv_raw_i[gi];
      assign mon_bus[gi].ov_len = monitor_ov_filter_select_i[gi] ? // R5
        vmr_pkg::CNT_W'(OV_LONG_CYC) : vmr_pkg::CNT_W'(vmr_pkg::OV_T0_CYC);
      always_comb begin
        case (monitor_uv_filter_select_i[2*gi +: 2]) // R5
          2'h0: mon_bus[gi].uv_len = vmr_pkg::CNT_W'(vmr_pkg::UV_T0_CYC);
          2'h1: mon_bus[gi].uv_len = vmr_pkg::CNT_W'(vmr_pkg::UV_T1_CYC);
          2'h2: mon_bus[gi].uv_len = vmr_pkg::CNT_W'(vmr_pkg::UV_T2_CYC);
          default: mon_bus[gi].uv_len = vmr_pkg::CNT_W'(vmr_pkg::UV_T3_CYC);
        endcase
      end
      assign ov_filt[gi] = mon_bus[gi].ov_filt;
      assign uv_filt[gi] = mon_bus[gi].uv_filt;
      vmr_deglitch u_flt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .mon(mon_bus[gi])
      );
    end
  endgenerate

  // Configuration held from power-on reset
  logic [4*NM-1:0] reg_sel;
  logic [2*NM-1:0] ov_react;
  logic [2*NM-1:0] uv_react;
  logic [1:0] limit_code;
  logic [1:0] mid_react;
  logic [4*NM-1:0] next_reg_sel;
  logic [2*NM-1:0] next_ov_react;
  logic [2*NM-1:0] next_uv_react;
  logic [1:0] next_limit_code;
  logic [1:0] next_mid_react;

  always_comb begin
    next_reg_sel = reg_sel;
    next_ov_react = ov_react;
    next_uv_react = uv_react;
    next_limit_code = limit_code;
    next_mid_react = mid_react;
    if (cfg_write_i && initial_failsafe_phase_i) begin // R8
      next_reg_sel = monitor_regulator_select_i; // R1
      next_ov_react = monitor_overvoltage_reaction_i;
      next_uv_react = monitor_undervoltage_reaction_i;
      next_limit_code = fault_counter_limit_code_i;
      next_mid_react = fault_counter_midpoint_reaction_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_sel <= {NM{vmr_pkg::REG_EXTERNAL}};
      ov_react <= {NM{vmr_pkg::OV_REACT_RST}}; // R3 R15
      uv_react <= {NM{vmr_pkg::UV_REACT_RST}}; // R4 R15
      limit_code <= vmr_pkg::LIMIT_RST; // R9 R15
      mid_react <= vmr_pkg::MID_REACT_RST; // R10 R15
    end else begin
      reg_sel <= next_reg_sel;
      ov_react <= next_ov_react;
      uv_react <= next_uv_react;
      limit_code <= next_limit_code;
      mid_react <= next_mid_react;
    end
  end

  // Fault detection, flags, counter and reaction state
  vmr_pkg::vmr_state_t state;
  vmr_pkg::vmr_state_t next_state;
  logic [NM-1:0] ov_prev;
  logic [NM-1:0] uv_prev;
  logic [NM-1:0] ov_flag;
  logic [NM-1:0] uv_flag;
  logic [NM-1:0] next_ov_flag;
  logic [NM-1:0] next_uv_flag;
  logic [vmr_pkg::NUM_REG-1:0] reg_off;
  logic [vmr_pkg::NUM_REG-1:0] next_reg_off;
  logic [vmr_pkg::FLT_W-1:0] cnt;
  logic [vmr_pkg::FLT_W-1:0] next_cnt;
  logic [vmr_pkg::FLT_W-1:0] cnt_final;
  logic [vmr_pkg::FLT_W-1:0] cnt_mid;
  logic [7:0] pulse;
  logic [7:0] next_pulse;
  logic any_fs;
  logic any_rst;
  logic inc;
  logic mid_hit;
  logic rst_req;
  logic fs_req;

  always_comb begin
    next_ov_flag = ov_flag & ~ov_flag_clear_i;
    next_uv_flag = uv_flag & ~uv_flag_clear_i;
    next_reg_off = reg_off;
    any_fs = 1'b0;
    any_rst = 1'b0;
    for (int i = 0; i < NM; i++) begin
      if (ov_filt[i] && !ov_prev[i]) begin
        next_ov_flag[i] = 1'b1; // R2
        // Codes from the external value up only report the flag
        if (reg_sel[4*i +: 4] < vmr_pkg::REG_EXTERNAL) begin // R2
          next_reg_off[reg_sel[4*i +: 3]] = 1'b1; // R1
        end
        if (vmr_pkg::vmr_sev(ov_react[2*i +: 2]) == vmr_pkg::SEV_RST) begin
          any_rst = 1'b1; // R3
        end else if (vmr_pkg::vmr_sev(ov_react[2*i +: 2]) ==
                     vmr_pkg::SEV_FS) begin
          any_fs = 1'b1; // R3
        end
      end
      if (uv_filt[i] && !uv_prev[i]) begin
        next_uv_flag[i] = 1'b1;
        if (vmr_pkg::vmr_sev(uv_react[2*i +: 2]) == vmr_pkg::SEV_RST) begin
          any_rst = 1'b1; // R4
        end else if (vmr_pkg::vmr_sev(uv_react[2*i +: 2]) ==
                     vmr_pkg::SEV_FS) begin
          any_fs = 1'b1; // R4
        end
      end
    end
  end

  always_comb begin
    cnt_final = vmr_pkg::vmr_final(limit_code); // R9
    cnt_mid = vmr_pkg::vmr_mid(limit_code); // R9
    // Faults count only while both pins are released
    inc = 1'b0;
    if (state == vmr_pkg::ST_NORMAL) begin
      inc = any_fs || any_rst; // R12
    end else if (state == vmr_pkg::ST_FS || state == vmr_pkg::ST_RST) begin
      inc = wd_err_max_i; // R13
    end
    next_cnt = cnt;
    mid_hit = 1'b0;
    if (inc && cnt < cnt_final) begin // R14
      next_cnt = cnt + vmr_pkg::FLT_ONE;
      mid_hit = (cnt + vmr_pkg::FLT_ONE) == cnt_mid; // R14
    end
    if (standby_exit_i) begin
      next_cnt = vmr_pkg::CNT_START; // R6
      mid_hit = 1'b0;
    end
    // Reactions act in normal and fail-safe states, not during the reset pulse or deep fail-safe
    rst_req = any_rst || // R3 R4
      (mid_hit && vmr_pkg::vmr_sev(mid_react) == vmr_pkg::SEV_RST); // R10
    fs_req = any_fs ||
      (mid_hit && vmr_pkg::vmr_sev(mid_react) == vmr_pkg::SEV_FS); // R10
    next_state = state;
    next_pulse = pulse;
    case (state)
      vmr_pkg::ST_NORMAL: begin
        if (rst_req) begin
          next_state = vmr_pkg::ST_RST;
          next_pulse = 8'(vmr_pkg::RST_PULSE_CYC - 1);
        end else if (fs_req) begin
          next_state = vmr_pkg::ST_FS;
        end
      end
      vmr_pkg::ST_FS: begin
        if (rst_req) begin
          next_state = vmr_pkg::ST_RST;
          next_pulse = 8'(vmr_pkg::RST_PULSE_CYC - 1);
        end else if (failsafe_release_i) begin
          next_state = vmr_pkg::ST_NORMAL;
        end
      end
      vmr_pkg::ST_RST: begin
        // Reset pulse ends into fail-safe asserted
        if (pulse == 8'h00) begin
          next_state = vmr_pkg::ST_FS;
        end else begin
          next_pulse = pulse - 8'h01;
        end
      end
      // Only power-on reset leaves deep fail-safe
      vmr_pkg::ST_DEEP: next_state = vmr_pkg::ST_DEEP; // R7
      default: next_state = vmr_pkg::ST_DEEP;
    endcase
    // Final value overrides every other transition
    if (next_cnt >= cnt_final) begin
      next_state = vmr_pkg::ST_DEEP; // R7
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= vmr_pkg::ST_NORMAL;
      cnt <= vmr_pkg::CNT_START; // R6
      pulse <= 8'h00;
      ov_prev <= '0;
      uv_prev <= '0;
      ov_flag <= '0;
      uv_flag <= '0;
      reg_off <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pulse <= next_pulse;
      ov_prev <= ov_filt;
      uv_prev <= uv_filt;
      ov_flag <= next_ov_flag;
      uv_flag <= next_uv_flag;
      reg_off <= next_reg_off;
    end
  end

  // Next values of the registered output stage
  logic next_rst_pin_n;
  logic next_fs_pin_n;
  logic next_deep;
  logic next_mid_out;
  logic next_final_out;

  // Deep fail-safe drives both pins low
  always_comb begin
    next_rst_pin_n = !(state == vmr_pkg::ST_RST ||
                       state == vmr_pkg::ST_DEEP);
    next_fs_pin_n = state == vmr_pkg::ST_NORMAL;
    next_deep = state == vmr_pkg::ST_DEEP;
    next_mid_out = cnt >= cnt_mid; // R11
    next_final_out = cnt >= cnt_final; // R11
  end

  // Registered output stage, one cycle after the state it shows
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      regulator_off_o <= '0;
      ov_flag_o <= '0;
      uv_flag_o <= '0;
      reset_output_pin_n_o <= 1'b1;
      failsafe_output_pin_n_o <= 1'b1;
      deep_failsafe_o <= 1'b0;
      fault_counter_value_o <= vmr_pkg::CNT_START;
      cnt_intermediate_o <= 1'b0;
      cnt_final_o <= 1'b0;
    end else begin
      regulator_off_o <= reg_off;
      ov_flag_o <= ov_flag;
      uv_flag_o <= uv_flag;
      reset_output_pin_n_o <= next_rst_pin_n;
      failsafe_output_pin_n_o <= next_fs_pin_n;
      deep_failsafe_o <= next_deep;
      fault_counter_value_o <= cnt;
      cnt_intermediate_o <= next_mid_out;
      cnt_final_o <= next_final_out;
    end
  end
endmodule

/* File: vmr_host.sv */
// Host model: config writes, flag clears and fail-safe release
`timescale 1ns/100ps
module vmr_host (
  input wire logic ref_clk_i,
  output logic cfg_write_o,
  output logic phase_o,
  output logic [15:0] regsel_o,
  output logic [7:0] ovr_o,
  output logic [7:0] uvr_o,
  output logic [1:0] lim_o,
  output logic [1:0] mid_o,
  output logic rel_o,
  output logic [3:0] clr_o
);
  initial begin
    {cfg_write_o, phase_o, regsel_o, ovr_o, uvr_o, lim_o, mid_o} = '0;
    {rel_o, clr_o} = 5'h00;
  end
  task automatic cfg(input logic [36:0] v);
    @(negedge ref_clk_i);
    {phase_o, regsel_o, ovr_o, uvr_o, lim_o, mid_o} = v;
    cfg_write_o = 1'b1;
    @(negedge ref_clk_i);
    cfg_write_o = 1'b0;
    phase_o = 1'b0;
  endtask
  task automatic pulse(input logic [4:0] v);
    @(negedge ref_clk_i);
    {rel_o, clr_o} = v;
    @(negedge ref_clk_i);
    {rel_o, clr_o} = 5'h00;
  endtask
endmodule

/* File: vmr_checker.sv */
// Port-level assertions for the monitor fault reaction block
`timescale 1ns/100ps
module vmr_checker #(
  parameter int OV_LONG_CYC = 40
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic standby_exit_i,
  input wire logic wd_err_max_i,
  input wire logic [3:0] mon_ov_raw_i,
  input wire logic [3:0] ov_flag_o,
  input wire logic reset_output_pin_n_o,
  input wire logic failsafe_output_pin_n_o,
  input wire logic deep_failsafe_o,
  input wire logic [3:0] fault_counter_value_o,
  input wire logic cnt_intermediate_o,
  input wire logic cnt_final_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_start_level: assert property ($rose(rst_n_i) |->
    fault_counter_value_o == 4'h1 && !cnt_final_o && !cnt_intermediate_o)
    else $error("counter not at start level after reset");
  chk_standby_start: assert property (standby_exit_i |-> ##2
    fault_counter_value_o == 4'h1) else $error("standby exit kept count");
  chk_step_one: assert property ($changed(fault_counter_value_o) &&
    !$past(standby_exit_i, 2) |-> fault_counter_value_o ==
    $past(fault_counter_value_o) + 4'h1) else $error("count jumped");
  chk_wd_adds: assert property (wd_err_max_i && !standby_exit_i ##1
    !failsafe_output_pin_n_o && !cnt_final_o |=> fault_counter_value_o ==
    $past(fault_counter_value_o) + 4'h1) else $error("watchdog not counted");
  chk_final_holds: assert property (cnt_final_o &&
    !$past(standby_exit_i) |=> $stable(fault_counter_value_o))
    else $error("counter wrapped");
  chk_final_deep: assert property ($rose(cnt_final_o) |-> ##[0:3]
    deep_failsafe_o) else $error("final value without deep state");
  chk_deep_pins: assert property (deep_failsafe_o |=>
    !reset_output_pin_n_o && !failsafe_output_pin_n_o)
    else $error("deep state with pins released");
  chk_rst_has_fs: assert property (!reset_output_pin_n_o |->
    !failsafe_output_pin_n_o) else $error("reset without fail-safe");
  chk_mid_before_final: assert property (cnt_final_o |->
    cnt_intermediate_o) else $error("final without intermediate");
  chk_flag_filtered: assert property ($rose(ov_flag_o[0]) |->
    $past(mon_ov_raw_i[0], 8)) else $error("flag set before filter time");
endmodule
bind vmr_top vmr_checker #(.OV_LONG_CYC(OV_LONG_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .standby_exit_i(standby_exit_i), .wd_err_max_i(wd_err_max_i),
  .mon_ov_raw_i(mon_ov_raw_i), .ov_flag_o(ov_flag_o),
  .reset_output_pin_n_o(reset_output_pin_n_o),
  .failsafe_output_pin_n_o(failsafe_output_pin_n_o),
  .deep_failsafe_o(deep_failsafe_o),
  .fault_counter_value_o(fault_counter_value_o),
  .cnt_intermediate_o(cnt_intermediate_o), .cnt_final_o(cnt_final_o));

/* File: tb.sv */
// Self-checking bench for the monitor fault reaction block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  localparam int OVN = 40;
  int error_cnt = 0;
  int checks_done = 0;
  logic ref_clk_i, rst_n_i, sb, wd, cw, ph, rel, rp, fp, dp, ci, cf;
  logic [3:0] ovr, uvr, clr, ovf, uvf, cnt, ofs;
  logic [15:0] rs;
  logic [7:0] ovc, uvc, roff, ufs;
  logic [1:0] lim, mid;
  vmr_top #(.OV_LONG_CYC(OVN)) i_dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .standby_exit_i(sb), .mon_ov_raw_i(ovr),
    .mon_uv_raw_i(uvr), .monitor_ov_filter_select_i(ofs),
    .monitor_uv_filter_select_i(ufs), .initial_failsafe_phase_i(ph),
    .cfg_write_i(cw), .monitor_regulator_select_i(rs),
    .monitor_overvoltage_reaction_i(ovc),
    .monitor_undervoltage_reaction_i(uvc),
    .fault_counter_limit_code_i(lim),
    .fault_counter_midpoint_reaction_i(mid), .wd_err_max_i(wd),
    .failsafe_release_i(rel), .ov_flag_clear_i(clr),
    .uv_flag_clear_i(clr), .regulator_off_o(roff), .ov_flag_o(ovf),
    .uv_flag_o(uvf), .reset_output_pin_n_o(rp),
    .failsafe_output_pin_n_o(fp), .deep_failsafe_o(dp),
    .fault_counter_value_o(cnt), .cnt_intermediate_o(ci),
    .cnt_final_o(cf));
  vmr_host i_host (.ref_clk_i(ref_clk_i), .cfg_write_o(cw), .phase_o(ph),
    .regsel_o(rs), .ovr_o(ovc), .uvr_o(uvc), .lim_o(lim), .mid_o(mid),
    .rel_o(rel), .clr_o(clr));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic por_defaults();
    rst_n_i = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    `CHK({roff, ovf, uvf, rp, fp, dp, ci, cf}, 21'h18)
    `CHK(cnt, 4'h1)
  endtask
  task automatic fault(input bit ov, input int m, input int n,
    input logic [1:0] pins, input logic [3:0] c, input logic r);
    int k;
    @(negedge ref_clk_i);
    if (ov) ovr[m] = 1'b1;
    else uvr[m] = 1'b1;
    repeat (n - 1) @(negedge ref_clk_i);
    `CHK(ovf | uvf, 4'h0)
    k = 0;
    while ((ovf | uvf) === 4'h0 && k < 20) begin
      @(negedge ref_clk_i);
      k++;
    end
    repeat (3) @(negedge ref_clk_i);
    `CHK(ov ? ovf : uvf, 4'h1 << m)
    `CHK({rp, fp}, pins)
    `CHK(cnt, c)
    ovr = 4'h0;
    uvr = 4'h0;
    repeat (n + 5) @(negedge ref_clk_i);
    i_host.pulse({r, 4'hf});
    repeat (4) @(negedge ref_clk_i);
    if (r) `CHK({rp, fp}, 2'h3)
  endtask
  initial begin
    {sb, wd, ovr, uvr} = '0;
    // Long OV filter everywhere; monitor 3 UV on the 15 us filter
    ofs = 4'hf;
    ufs = 8'h40;
    por_defaults();
    // Limit 8/4, midpoint fs+reset, monitor 1 drives regulator 3
    i_host.cfg({1'b1, 16'h8838, 8'hc6, 8'h55, 2'h2, 2'h3});
    i_host.cfg({1'b0, 16'h8888, 8'h00, 8'h00, 2'h0, 2'h0});
    fault(1'b1, 2, OVN, 2'h3, 4'h1, 1'b0);
    fault(1'b0, 3, vmr_pkg::UV_T1_CYC, 2'h2, 4'h2, 1'b1);
    fault(1'b1, 0, OVN, 2'h0, 4'h3, 1'b1);
    `CHK(roff, 8'h00)
    fault(1'b1, 1, OVN, 2'h0, 4'h4, 1'b0);
    `CHK({roff, ci, cf}, 10'h022)
    repeat (5) begin
      @(negedge ref_clk_i);
      wd = 1'b1;
      @(negedge ref_clk_i);
      wd = 1'b0;
    end
    repeat (4) @(negedge ref_clk_i);
    `CHK({cnt, dp, ci, cf}, 7'h47)
    @(negedge ref_clk_i);
    sb = 1'b1;
    @(negedge ref_clk_i);
    sb = 1'b0;
    @(negedge ref_clk_i);
    `CHK({cnt, dp}, 5'h03)
    por_defaults();
    ofs = 4'hd;
    fault(1'b1, 1, vmr_pkg::OV_T0_CYC, 2'h0, 4'h2, 1'b1);
    `CHK(roff, 8'h00)
    // Lowest limit 2/1 puts a count of two at the final value
    i_host.cfg({1'b1, 16'h8888, 8'hff, 8'hff, 2'h0, 2'h0});
    repeat (3) @(negedge ref_clk_i);
    `CHK({dp, ci, cf}, 3'h7)
    tally_and_finish();
  end
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
